/* pata_pkg.sv */
package pata_pkg;
  // ==========================================================
  // host-side request kinds
  localparam logic [1:0] REQ_CMD_BLK = 2'h0;
  localparam logic [1:0] REQ_CTRL_BLK = 2'h1;
  localparam logic [1:0] REQ_DMA = 2'h2;
  // ==========================================================
  // strobe timing in ns and derived cycles at 50 MHz
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETUP_NS = 70;
  localparam int STROBE_NS = 165;
  localparam int RECOVER_NS = 30;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC =
    (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC =
    (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // ==========================================================
  // widths and reset values
  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int FIFO_DEPTH = 4;
  localparam logic SEL_IDLE = 1'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  typedef enum logic [2:0] {
    PATA_IDLE, PATA_SETUP, PATA_STROBE, PATA_RECOVER, PATA_PUSH
  } pata_state_e;
endpackage

/* pata_fifo.sv */
`timescale 1ns/1ns
module pata_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic wr, rd;

  always_comb begin
    wr = in_valid && in_ready;
    rd = out_valid && out_ready;
    wp_nxt = wr ? wp_r + 1'b1 : wp_r;
    rp_nxt = rd ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
  end

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule

/* pata_chan.sv */
`timescale 1ns/1ns
// Behaviour
// - ctrl_block_select_n goes low only for control-block (3F0-3F7) cycles.
// - both selects and the dma ack sit high in and after reset and in suspend.
// - disk_data is driven by this end only while it writes, else released.
// - disk_dma_ack_n low marks a strobe cycle as a dma data cycle.
// - dma request and ack are serviced only by the bus-master engine port.
// - in master/slave mode the pins serve the master connector, else primary.
// - cmd_block_select_n goes low only for command-block (1F0-1F7) cycles.
// - read data is captured when the read strobe is negated.
module pata_chan (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // mode
  input wire logic suspend,
  input wire logic master_slave_mode,
  input wire logic dma_armed,
  input wire logic dma_dir_write,
  // register access request
  input wire logic pio_req,
  input wire logic pio_ctrl_blk,
  input wire logic pio_write,
  input wire logic [2:0] pio_addr,
  input wire logic [15:0] pio_wdata,
  output logic pio_busy,
  // dma write data from bus-master engine
  input wire logic [15:0] dma_wdata,
  output logic dma_wtake,
  // read data stream to engine
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [15:0] rd_data,
  output logic rd_is_dma,
  // disk pins
  output logic ctrl_block_select_n,
  output logic cmd_block_select_n,
  output logic disk_dma_ack_n,
  input wire logic disk_dma_req,
  output logic [2:0] disk_reg_addr,
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  input wire logic [15:0] disk_data_in,
  output logic [15:0] disk_data_out,
  output logic [15:0] disk_data_oe,
  output logic port_serves_master
);
  // ==========================================================
  // input synchronisers
  logic [1:0] req_sync_r;
  logic [15:0] din_s1_r, din_s2_r;
  logic susp_s1_r, susp_s2_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      req_sync_r <= 2'h0;
      din_s1_r <= pata_pkg::DATA_RST;
      din_s2_r <= pata_pkg::DATA_RST;
      susp_s1_r <= 1'h0;
      susp_s2_r <= 1'h0;
    end else begin
      req_sync_r <= {req_sync_r[0], disk_dma_req};
      din_s1_r <= disk_data_in;
      din_s2_r <= din_s1_r;
      susp_s1_r <= suspend;
      susp_s2_r <= susp_s1_r;
    end
  end
  logic dreq;
  assign dreq = req_sync_r[1];

  // ==========================================================
  // read stream buffer
  logic dma_r, dma_nxt, wr_r, wr_nxt, ctl_r, ctl_nxt;
  logic [15:0] wd_r, wd_nxt, cap_r, cap_nxt;
  logic f_in_valid, f_in_ready;
  logic [16:0] f_out;
  logic f_out_valid;
  pata_fifo #(.WIDTH(17), .DEPTH(pata_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data({dma_r, cap_r}),
    .out_valid(f_out_valid),
    .out_ready(rd_ready || !rd_valid),
    .out_data(f_out)
  );

  // ==========================================================
  // cycle sequencer
  pata_pkg::pata_state_e st_r, st_nxt;
  logic [pata_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [2:0] addr_r, addr_nxt;
  logic take_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    dma_nxt = dma_r;
    wr_nxt = wr_r;
    ctl_nxt = ctl_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    cap_nxt = cap_r;
    take_nxt = 1'b0;
    f_in_valid = 1'b0;
    case (st_r)
      pata_pkg::PATA_IDLE: begin
        if (susp_s2_r) begin
          st_nxt = pata_pkg::PATA_IDLE;
        end else if (dreq && dma_armed) begin
          dma_nxt = 1'b1;
          wr_nxt = dma_dir_write;
          wd_nxt = dma_wdata;
          take_nxt = dma_dir_write;
          cnt_nxt = pata_pkg::CNT_W'(pata_pkg::SETUP_CYC);
          st_nxt = pata_pkg::PATA_SETUP;
        end else if (pio_req) begin
          dma_nxt = 1'b0;
          wr_nxt = pio_write;
          ctl_nxt = pio_ctrl_blk;
          addr_nxt = pio_addr;
          wd_nxt = pio_wdata;
          cnt_nxt = pata_pkg::CNT_W'(pata_pkg::SETUP_CYC);
          st_nxt = pata_pkg::PATA_SETUP;
        end
      end
      pata_pkg::PATA_SETUP: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == 4'h1) begin
          cnt_nxt = pata_pkg::CNT_W'(pata_pkg::STROBE_CYC);
          st_nxt = pata_pkg::PATA_STROBE;
        end
      end
      pata_pkg::PATA_STROBE: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == 4'h1) begin
          if (!wr_r) begin
            cap_nxt = din_s2_r;
          end
          cnt_nxt = pata_pkg::CNT_W'(pata_pkg::RECOVER_CYC);
          st_nxt = pata_pkg::PATA_RECOVER;
        end
      end
      pata_pkg::PATA_RECOVER: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == 4'h1) begin
          st_nxt = wr_r ? pata_pkg::PATA_IDLE : pata_pkg::PATA_PUSH;
        end
      end
      pata_pkg::PATA_PUSH: begin
        f_in_valid = 1'b1;
        if (f_in_ready) begin
          st_nxt = pata_pkg::PATA_IDLE;
        end
      end
      default: st_nxt = pata_pkg::PATA_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= pata_pkg::PATA_IDLE;
      cnt_r <= '0;
      dma_r <= 1'b0;
      wr_r <= 1'b0;
      ctl_r <= 1'b0;
      addr_r <= pata_pkg::ADDR_RST;
      wd_r <= pata_pkg::DATA_RST;
      cap_r <= pata_pkg::DATA_RST;
      dma_wtake <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      dma_r <= dma_nxt;
      wr_r <= wr_nxt;
      ctl_r <= ctl_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      cap_r <= cap_nxt;
      dma_wtake <= take_nxt;
    end
  end

  // ==========================================================
  // registered pin drivers
  logic act, stb;
  always_comb begin
    // suspend parks every select and strobe high, even mid-cycle
    act = !susp_s2_r && ((st_nxt == pata_pkg::PATA_SETUP) ||
          (st_nxt == pata_pkg::PATA_STROBE) ||
          (st_nxt == pata_pkg::PATA_RECOVER));
    stb = !susp_s2_r && (st_nxt == pata_pkg::PATA_STROBE);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_block_select_n <= pata_pkg::SEL_IDLE;
      cmd_block_select_n <= pata_pkg::SEL_IDLE;
      disk_dma_ack_n <= pata_pkg::SEL_IDLE;
      io_read_strobe_n <= pata_pkg::SEL_IDLE;
      io_write_strobe_n <= pata_pkg::SEL_IDLE;
      disk_reg_addr <= pata_pkg::ADDR_RST;
      disk_data_out <= pata_pkg::DATA_RST;
      disk_data_oe <= 16'h0000;
      pio_busy <= 1'b0;
      port_serves_master <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= pata_pkg::DATA_RST;
      rd_is_dma <= 1'b0;
    end else begin
      ctrl_block_select_n <= !(act && !dma_nxt && ctl_nxt);
      cmd_block_select_n <= !(act && !dma_nxt && !ctl_nxt);
      disk_dma_ack_n <= !(act && dma_nxt);
      io_read_strobe_n <= !(stb && !wr_nxt);
      io_write_strobe_n <= !(stb && wr_nxt);
      disk_reg_addr <= addr_nxt;
      disk_data_out <= wd_nxt;
      disk_data_oe <= {16{act && wr_nxt}};
      pio_busy <= (st_nxt != pata_pkg::PATA_IDLE);
      port_serves_master <= master_slave_mode;
      if (rd_ready || !rd_valid) begin
        rd_valid <= f_out_valid;
        rd_data <= f_out[15:0];
        rd_is_dma <= f_out[16];
      end
    end
  end
endmodule

/* pata_chan_asserts.sv */
`timescale 1ns/1ns
// ==========================================
// pin checks for the channel
module pata_chan_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // mode
  input wire logic suspend,
  input wire logic master_slave_mode,
  input wire logic dma_armed,
  input wire logic pio_busy,
  // disk pins
  input wire logic ctrl_block_select_n,
  input wire logic cmd_block_select_n,
  input wire logic disk_dma_ack_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic [15:0] disk_data_oe,
  input wire logic port_serves_master
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  wire logic sel_on;
  assign sel_on = !(ctrl_block_select_n & cmd_block_select_n & disk_dma_ack_n);
  sequence rd_rest;
    (!io_read_strobe_n)[*8] ##1 io_read_strobe_n;
  endsequence
  sequence wr_rest;
    (!io_write_strobe_n)[*8] ##1 io_write_strobe_n;
  endsequence
  chk_ctrl_excl: assert property (!ctrl_block_select_n |->
    cmd_block_select_n && disk_dma_ack_n) else $error("two selects low");
  chk_cmd_excl: assert property (!cmd_block_select_n |->
    disk_dma_ack_n) else $error("cmd select with ack");
  chk_susp_idle: assert property (suspend[*4] |-> !sel_on)
    else $error("select low in suspend");
  chk_ack_armed: assert property ($fell(disk_dma_ack_n) |->
    $past(dma_armed)) else $error("ack without armed transfer");
  chk_ack_busy: assert property (!disk_dma_ack_n |-> pio_busy)
    else $error("ack outside a cycle");
  chk_rd_pulse: assert property ($fell(io_read_strobe_n) |=> rd_rest)
    else $error("read strobe width");
  chk_wr_pulse: assert property ($fell(io_write_strobe_n) |=> wr_rest)
    else $error("write strobe width");
  chk_rd_release: assert property (!io_read_strobe_n |->
    disk_data_oe == 16'h0000) else $error("driving during read");
  chk_wr_drive: assert property (!io_write_strobe_n |->
    disk_data_oe == 16'hffff) else $error("released during write");
  chk_sel_lead: assert property ($fell(io_read_strobe_n) ||
    $fell(io_write_strobe_n) |-> $past(sel_on, 4)) else $error("no select");
  chk_mode_echo: assert property ($past(rstn) |->
    port_serves_master == $past(master_slave_mode)) else $error("mode echo");
endmodule
bind pata_chan pata_chan_asserts chk (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .suspend(suspend),
  .master_slave_mode(master_slave_mode),
  .dma_armed(dma_armed),
  .pio_busy(pio_busy),
  .ctrl_block_select_n(ctrl_block_select_n),
  .cmd_block_select_n(cmd_block_select_n),
  .disk_dma_ack_n(disk_dma_ack_n),
  .io_read_strobe_n(io_read_strobe_n),
  .io_write_strobe_n(io_write_strobe_n),
  .disk_data_oe(disk_data_oe),
  .port_serves_master(port_serves_master)
);

/* pata_disk_model.sv */
`timescale 1ns/1ns
// ==========================================
// disk on the far side of the pins
module pata_disk_model (
  // strobe from the channel
  input wire logic io_read_strobe_n,
  // data and request back
  output logic [15:0] disk_data_in,
  output logic disk_dma_req,
  // bench control
  input wire logic req_en,
  input wire logic [15:0] rd_word
);
  initial disk_data_in = 16'h0000;
  assign disk_dma_req = req_en;
  // drive under the read strobe only, else flip the stale value
  always @(io_read_strobe_n)
    disk_data_in = io_read_strobe_n ? ~disk_data_in : rd_word;
endmodule

/* pata_chan_tb.sv */
`timescale 1ns/1ns
// ==========================================
// bench for the channel pins
module pata_chan_tb;
  logic clk_sys = 1'b0, rstn = 1'b0, suspend = 1'b0, dma_armed = 1'b0;
  logic master_slave_mode = 1'b0, dma_dir_write = 1'b0, pio_req = 1'b0;
  logic pio_ctrl_blk = 1'b0, pio_write = 1'b0, rd_ready = 1'b0;
  logic req_en = 1'b0, mdma = 1'b0, mctl = 1'b0, stall = 1'b0;
  logic [2:0] pio_addr = 3'h0;
  logic [15:0] pio_wdata = 16'h0000, dma_wdata = 16'h0000;
  logic [15:0] rd_word = 16'h0000, exp_w = 16'h0000;
  logic pio_busy, dma_wtake, rd_valid, rd_is_dma, ctrl_block_select_n;
  logic cmd_block_select_n, disk_dma_ack_n, disk_dma_req, io_read_strobe_n;
  logic io_write_strobe_n, port_serves_master;
  logic [2:0] disk_reg_addr;
  logic [15:0] rd_data, disk_data_in, disk_data_out, disk_data_oe;
  logic [16:0] exp_q[$];
  logic [16:0] exp_d;
  int seed = 88, err_total = 0, num_checks = 0, cyc = 0, ntake = 0, nws = 0;
  pata_chan dut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .suspend(suspend),
    .master_slave_mode(master_slave_mode),
    .dma_armed(dma_armed),
    .dma_dir_write(dma_dir_write),
    .pio_req(pio_req),
    .pio_ctrl_blk(pio_ctrl_blk),
    .pio_write(pio_write),
    .pio_addr(pio_addr),
    .pio_wdata(pio_wdata),
    .pio_busy(pio_busy),
    .dma_wdata(dma_wdata),
    .dma_wtake(dma_wtake),
    .rd_valid(rd_valid),
    .rd_ready(rd_ready),
    .rd_data(rd_data),
    .rd_is_dma(rd_is_dma),
    .ctrl_block_select_n(ctrl_block_select_n),
    .cmd_block_select_n(cmd_block_select_n),
    .disk_dma_ack_n(disk_dma_ack_n),
    .disk_dma_req(disk_dma_req),
    .disk_reg_addr(disk_reg_addr),
    .io_read_strobe_n(io_read_strobe_n),
    .io_write_strobe_n(io_write_strobe_n),
    .disk_data_in(disk_data_in),
    .disk_data_out(disk_data_out),
    .disk_data_oe(disk_data_oe),
    .port_serves_master(port_serves_master)
  );
  pata_disk_model disk (
    .io_read_strobe_n(io_read_strobe_n),
    .disk_data_in(disk_data_in),
    .disk_dma_req(disk_dma_req),
    .req_en(req_en),
    .rd_word(rd_word)
  );
  always #10 clk_sys = ~clk_sys;
  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    rd_ready <= !stall && ($random(seed) % 2 != 0);
    if (dma_wtake === 1'b1) ntake++;
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      exp_d = exp_q.size() ? exp_q.pop_front() : 17'hx;
      cmp({rd_is_dma, rd_data}, exp_d);
    end
    if (cyc == 5000) begin
      err_total++;
      results;
    end
  end
  always @(posedge io_read_strobe_n) rd_word <= 16'($random(seed));
  always @(negedge io_read_strobe_n or negedge io_write_strobe_n) begin
    cmp({14'h0, ctrl_block_select_n, cmd_block_select_n, disk_dma_ack_n},
      {14'h0, mdma | !mctl, mdma | mctl, !mdma});
    if (!mdma) cmp({14'h0, disk_reg_addr}, {14'h0, pio_addr});
    cmp({16'h0, port_serves_master}, {16'h0, master_slave_mode});
    if (!io_read_strobe_n) begin
      exp_q.push_back({mdma, rd_word});
      cmp({1'b0, disk_data_oe}, 17'h00000);
    end else begin
      nws += mdma;
      cmp({1'b0, disk_data_out}, {1'b0, exp_w});
    end
  end
  task automatic pio(input logic c, input logic w);
    logic [15:0] d;
    d = 16'($random(seed));
    @(posedge clk_sys);
    mdma = 1'b0;
    mctl = c;
    exp_w = d;
    pio_ctrl_blk <= c;
    pio_write <= w;
    pio_addr <= d[2:0];
    pio_wdata <= d;
    master_slave_mode <= d[15];
    pio_req <= 1'b1;
    do @(negedge clk_sys); while (pio_busy !== 1'b1);
    @(posedge clk_sys);
    pio_req <= 1'b0;
    do @(negedge clk_sys); while (pio_busy !== 1'b0);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic dma(input logic w, input int n);
    @(posedge clk_sys);
    mdma = 1'b1;
    exp_w = 16'($random(seed));
    dma_wdata <= exp_w;
    dma_dir_write <= w;
    dma_armed <= 1'b1;
    req_en <= 1'b1;
    repeat (n) @(negedge io_read_strobe_n or negedge io_write_strobe_n);
    @(posedge clk_sys);
    dma_armed <= 1'b0;
    req_en <= 1'b0;
    do @(negedge clk_sys); while (pio_busy !== 1'b0);
    repeat (4) @(posedge clk_sys);
    cmp(17'(ntake), 17'(nws));
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) pio(i[0], i[1]);
    $display("register cycles done");
    dma(1'b0, 3);
    dma(1'b1, 3);
    $display("dma bursts done");
    stall <= 1'b1;
    fork
      dma(1'b0, 6);
      begin
        repeat (150) @(posedge clk_sys);
        stall <= 1'b0;
      end
    join
    $display("full buffer done");
    suspend <= 1'b1;
    req_en <= 1'b1;
    // let suspend clear its synchroniser before the request
    repeat (3) @(posedge clk_sys);
    fork
      pio(1'b1, 1'b0);
      begin
        repeat (40) @(negedge clk_sys);
        cmp({16'h0, pio_busy}, 17'h0);
        @(posedge clk_sys);
        suspend <= 1'b0;
      end
    join
    req_en <= 1'b0;
    $display("suspend done");
    while (exp_q.size() != 0) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    results;
  end
endmodule
